//--- core/sac_regs.vh
// Register map, field positions, reset values and timing counts of the
// converter control block.
// Assumes a Wishbone slave with word-aligned registers: byte address is 4 x index.
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// ********************************************************************
// Register indices
// ********************************************************************
`define SAC_IDX_CTRL        6'h1F
`define SAC_IDX_RES_HIGH    6'h1E
`define SAC_IDX_RES_LOW     6'h20
`define SAC_IDX_PORT_CFG    6'h21
`define SAC_IDX_IRQ_STATUS  6'h22
`define SAC_IDX_IRQ_MASK    6'h23

// ********************************************************************
// Control register fields
// ********************************************************************
`define SAC_CTRL_CLK_HI     7
`define SAC_CTRL_CLK_LO     6
`define SAC_CTRL_CHAN_HI    5
`define SAC_CTRL_CHAN_LO    3
`define SAC_CTRL_GO         2
`define SAC_CTRL_ON         0
`define SAC_CTRL_RESET      8'h00

// ********************************************************************
// Port configuration fields
// ********************************************************************
`define SAC_PCFG_REFH       8
`define SAC_PCFG_REFL       9
`define SAC_PCFG_RESET      10'h000
`define SAC_REFH_PIN        3
`define SAC_REFL_PIN        2

// ********************************************************************
// Interrupt fields
// ********************************************************************
`define SAC_IRQ_DONE        0
`define SAC_IRQ_RESET       1'h0

// ********************************************************************
// Conversion clock and sequence counts
// ********************************************************************
`define SAC_CLK_FOSC2       2'h0
`define SAC_CLK_FOSC8       2'h1
`define SAC_CLK_FOSC32      2'h2
`define SAC_CLK_RC          2'h3
`define SAC_DIV_FOSC2       6'h02
`define SAC_DIV_FOSC8       6'h08
`define SAC_DIV_FOSC32      6'h20
`define SAC_SETUP_TADS      2'h1
`define SAC_HOLDOFF_TADS    2'h2
`define SAC_RES_BITS        10

`endif

//--- core/sac_conv_clock.v
// Conversion clock period generator: one-cycle tick per conversion clock period.
// Assumes the RC oscillator tick arrives synchronous to sys_clk.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_conv_clock (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       run,
    input  wire [1:0] clkSel,
    input  wire       rcTick,
    input  wire       sleepMode,
    output reg        tadTick
);
    reg  [5:0] divCount;
    wire [5:0] divLimit;

    assign divLimit = (clkSel == `SAC_CLK_FOSC2) ? `SAC_DIV_FOSC2 :
                      (clkSel == `SAC_CLK_FOSC8) ? `SAC_DIV_FOSC8 : `SAC_DIV_FOSC32;

    always @(posedge sys_clk) begin
        if (rst || !run) begin
            divCount <= 6'h00;
            tadTick  <= 1'b0;
        end else if (clkSel == `SAC_CLK_RC) begin
            // RC source keeps running in sleep
            divCount <= 6'h00;
            tadTick  <= rcTick;
        end else if (sleepMode) begin
            // System oscillator is stopped while asleep
            divCount <= 6'h00;
            tadTick  <= 1'b0;
        end else if (divCount == divLimit - 6'h01) begin
            divCount <= 6'h00;
            tadTick  <= 1'b1;
        end else begin
            divCount <= divCount + 6'h01;
            tadTick  <= 1'b0;
        end
    end
endmodule

//--- core/sac_sar_reg.v
// Successive approximation register: one bit trial per step, MSB first.
// Assumes compIn is high when the held input is at or above the DAC level.
`timescale 1ns/1ps

module sac_sar_reg #(
    parameter RES = 10
) (
    input  wire           sys_clk,
    input  wire           rst,
    input  wire           start,
    input  wire           abort,
    input  wire           step,
    input  wire           compIn,
    output reg  [RES-1:0] dacCode,
    output reg  [RES-1:0] result,
    output reg            done
);
    reg  [RES-1:0] trialBit;
    reg            busy;
    wire [RES-1:0] keep;

    assign keep = compIn ? dacCode : (dacCode & ~trialBit);

    always @(posedge sys_clk) begin
        if (rst || abort) begin
            trialBit <= {RES{1'b0}};
            dacCode  <= {RES{1'b0}};
            busy     <= 1'b0;
            done     <= 1'b0;
            if (rst)
                result <= {RES{1'b0}};
        end else begin
            done <= 1'b0;
            if (start) begin
                trialBit <= {1'b1, {(RES-1){1'b0}}};
                dacCode  <= {1'b1, {(RES-1){1'b0}}};
                busy     <= 1'b1;
            end else if (busy && step) begin
                trialBit <= trialBit >> 1;
                if (trialBit[0]) begin
                    dacCode <= keep;
                    result  <= keep;
                    busy    <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    dacCode <= keep | (trialBit >> 1);
                end
            end
        end
    end
endmodule

//--- core/sac_adc_control.v
// Control block of a 10-bit successive approximation converter, Wishbone slave.
// Assumes an external sample-hold, DAC and comparator that follow the outputs below.
//
// What this block does
// - Each conversion produces a 10-bit unsigned result by successive approximation.
// - Eight analog inputs exist, or five on the small variant (NUM_CH parameter).
// - Conversions continue in sleep only when the internal RC clock is selected.
// - Clock select bits 7-6 pick osc/2, osc/8, osc/32 or the internal RC clock.
// - Channel select bits 5-3 route channel 0 to 7 to the sample-hold stage.
// - Writing 1 to go/done while on starts a conversion; hardware clears it at the end.
// - The module-on bit 0 enables the converter; when 0 it is shut off.
// - The port configuration register makes each shared pin analog or digital.
// - High and low references are chosen from the supply rails or two reference pins.
// - The result is read through a high-part and a low-part register.
// - Two conversion clock periods with the hold capacitor disconnected follow a result.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_adc_control #(
    parameter NUM_CH = 8
) (
    input  wire              sys_clk,
    input  wire              rst,
    input  wire              cyc_i,
    input  wire              stb_i,
    input  wire              we_i,
    input  wire [7:0]        adr_i,
    input  wire [3:0]        sel_i,
    input  wire [31:0]       dat_i,
    output reg  [31:0]       dat_o,
    output reg               ack_o,
    input  wire              compIn,
    input  wire              rcTick,
    input  wire              sleepMode,
    output reg  [2:0]        analogChannel,
    output reg               holdConnect,
    output reg               converterEnable,
    output wire [9:0]        dacCode,
    output reg  [NUM_CH-1:0] pinAnalog,
    output reg               refHighFromPin,
    output reg               refLowFromPin,
    output wire              irq
);
    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_SETUP = 2'h1;
    localparam [1:0] ST_CONV  = 2'h2;
    localparam [1:0] ST_HOLD  = 2'h3;
    localparam [7:0] CTRL_RST = `SAC_CTRL_RESET;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [1:0]  clkSel;
    reg  [2:0]  chanSel;
    reg         goFlag;
    reg         moduleOn;
    reg  [9:0]  portCfg;
    reg  [9:0]  resultReg;
    reg         irqStatus;
    reg         irqMask;
    reg  [1:0]  state;
    reg  [1:0]  tadCount;
    reg         sarStart;

    wire        tadTick;
    wire [9:0]  sarResult;
    wire        sarDone;
    wire [5:0]  regIdx;
    wire        busReq;
    wire        wrLow;
    wire        wrByte1;
    wire        rdStrobe;
    wire        goWrite;
    wire [7:0]  ctrlView;

    assign regIdx   = adr_i[7:2];
    assign busReq   = cyc_i && stb_i && !ack_o;
    assign wrLow    = busReq && we_i && sel_i[0];
    assign wrByte1  = busReq && we_i && sel_i[1];
    assign rdStrobe = busReq && !we_i;
    // Go is only taken while the module is already on
    assign goWrite  = wrLow && (regIdx == `SAC_IDX_CTRL) && dat_i[`SAC_CTRL_GO] && moduleOn;
    // Bit 1 is tied low
    assign ctrlView = {clkSel, chanSel, goFlag, 1'b0, moduleOn};

    // ****************************************************************
    // Conversion clock and approximation register
    // ****************************************************************
    sac_conv_clock u_clock (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .run       (moduleOn),
        .clkSel    (clkSel),
        .rcTick    (rcTick),
        .sleepMode (sleepMode),
        .tadTick   (tadTick)
    );

    sac_sar_reg #(
        .RES (`SAC_RES_BITS)
    ) u_sar (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (sarStart),
        .abort   (!moduleOn),
        .step    (tadTick),
        .compIn  (compIn),
        .dacCode (dacCode),
        .result  (sarResult),
        .done    (sarDone)
    );

    // ****************************************************************
    // Control register
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            clkSel   <= CTRL_RST[`SAC_CTRL_CLK_HI:`SAC_CTRL_CLK_LO];
            chanSel  <= CTRL_RST[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO];
            goFlag   <= 1'b0;
            moduleOn <= 1'b0;
        end else begin
            if (wrLow && (regIdx == `SAC_IDX_CTRL)) begin
                clkSel   <= dat_i[`SAC_CTRL_CLK_HI:`SAC_CTRL_CLK_LO];
                chanSel  <= dat_i[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO];
                moduleOn <= dat_i[`SAC_CTRL_ON];
            end
            // A new start written in the end cycle wins over the clear
            if (goWrite)
                goFlag <= 1'b1;
            else if (sarDone || !moduleOn)
                goFlag <= 1'b0;
        end
    end

    // ****************************************************************
    // Port configuration and reference selection
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            portCfg <= `SAC_PCFG_RESET;
        end else begin
            if (wrLow && (regIdx == `SAC_IDX_PORT_CFG))
                portCfg[7:0] <= dat_i[7:0];
            if (wrByte1 && (regIdx == `SAC_IDX_PORT_CFG))
                portCfg[9:8] <= dat_i[9:8];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_CH; p = p + 1) begin : g_pin
            always @(posedge sys_clk) begin
                if (rst)
                    pinAnalog[p] <= 1'b0;
                else if (p == `SAC_REFH_PIN && portCfg[`SAC_PCFG_REFH])
                    pinAnalog[p] <= 1'b1;
                else if (p == `SAC_REFL_PIN && portCfg[`SAC_PCFG_REFL])
                    pinAnalog[p] <= 1'b1;
                else
                    pinAnalog[p] <= portCfg[p];
            end
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (rst) begin
            refHighFromPin  <= 1'b0;
            refLowFromPin   <= 1'b0;
            converterEnable <= 1'b0;
            analogChannel   <= 3'h0;
        end else begin
            refHighFromPin  <= portCfg[`SAC_PCFG_REFH];
            refLowFromPin   <= portCfg[`SAC_PCFG_REFL];
            converterEnable <= moduleOn;
            // Channels past NUM_CH fall back to channel 0 on the small variant
            if ({1'b0, chanSel} < NUM_CH)
                analogChannel <= chanSel;
            else
                analogChannel <= 3'h0;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    // Software owns the acquisition wait: holdConnect rises in idle and the
    // sequence starts as soon as go is seen, with no hardware settling time.
    always @(posedge sys_clk) begin
        if (rst || !moduleOn) begin
            state       <= ST_IDLE;
            tadCount    <= 2'h0;
            holdConnect <= 1'b0;
            sarStart    <= 1'b0;
        end else begin
            sarStart <= 1'b0;
            case (state)
                ST_IDLE: begin
                    holdConnect <= 1'b1;
                    if (goFlag) begin
                        holdConnect <= 1'b0;
                        tadCount    <= 2'h0;
                        state       <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tadTick) begin
                        if (tadCount == `SAC_SETUP_TADS - 2'h1) begin
                            sarStart <= 1'b1;
                            state    <= ST_CONV;
                        end
                        tadCount <= tadCount + 2'h1;
                    end
                end
                ST_CONV: begin
                    if (sarDone) begin
                        tadCount <= 2'h0;
                        state    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Capacitor stays cut off for the whole wait
                    holdConnect <= 1'b0;
                    if (tadTick) begin
                        if (tadCount == `SAC_HOLDOFF_TADS - 2'h1)
                            state <= ST_IDLE;
                        tadCount <= tadCount + 2'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Result and interrupt registers
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst)
            resultReg <= 10'h000;
        else if (sarDone && moduleOn)
            resultReg <= sarResult;
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            irqStatus <= `SAC_IRQ_RESET;
            irqMask   <= `SAC_IRQ_RESET;
        end else begin
            // A completion in the read cycle survives the read clear
            if (sarDone && moduleOn)
                irqStatus <= 1'b1;
            else if (rdStrobe && (regIdx == `SAC_IDX_IRQ_STATUS))
                irqStatus <= 1'b0;
            if (wrLow && (regIdx == `SAC_IDX_IRQ_MASK))
                irqMask <= dat_i[`SAC_IRQ_DONE];
        end
    end

    assign irq = irqStatus && irqMask;

    // ****************************************************************
    // Wishbone slave: one wait state, every access acknowledged
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= busReq;
            if (rdStrobe) begin
                if (regIdx == `SAC_IDX_CTRL)
                    dat_o <= {24'h00_0000, ctrlView};
                else if (regIdx == `SAC_IDX_RES_HIGH)
                    dat_o <= {30'h0000_0000, resultReg[9:8]};
                else if (regIdx == `SAC_IDX_RES_LOW)
                    dat_o <= {24'h00_0000, resultReg[7:0]};
                else if (regIdx == `SAC_IDX_PORT_CFG)
                    dat_o <= {22'h00_0000, portCfg};
                else if (regIdx == `SAC_IDX_IRQ_STATUS)
                    dat_o <= {31'h0000_0000, irqStatus};
                else if (regIdx == `SAC_IDX_IRQ_MASK)
                    dat_o <= {31'h0000_0000, irqMask};
                else
                    dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule

//--- test/sac_analog_model.sv
// Analog side model: eight source levels, a hold capacitor, a comparator, an RC clock.
// Assumes the bench sets the levels; slow makes the comparator answer a cycle late.
`timescale 1ns/1ps

module sac_analog_model #(
    parameter RC_PER = 5
) (
    input  logic       sys_clk,
    input  logic       slow,
    input  logic [9:0] level [0:7],
    input  logic [2:0] analogChannel,
    input  logic       holdConnect,
    input  logic [9:0] dacCode,
    output logic       compIn,
    output logic       rcTick
);
    logic [9:0] held = 10'h000;
    logic       compReg = 1'b0;
    int         rcCnt = 0;

    always @(posedge sys_clk) begin
        // Frozen while disconnected, so a late channel change cannot skew a result
        if (holdConnect) begin
            held <= level[analogChannel];
        end
        compReg <= held >= dacCode;
        rcCnt <= (rcCnt == RC_PER - 1) ? 0 : rcCnt + 1;
    end

    assign compIn = slow ? compReg : (held >= dacCode);
    assign rcTick = rcCnt == RC_PER - 1;
endmodule

//--- test/sac_adc_control_props.sv
// Checker of the converter control block, bound to the ports of its top module.
// Assumes one clock domain and the one wait state bus answer of the design.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_adc_control_props #(
    parameter NUM_CH = 8
) (
    input logic              sys_clk,
    input logic              rst,
    input logic              cyc_i,
    input logic              stb_i,
    input logic              we_i,
    input logic [7:0]        adr_i,
    input logic [3:0]        sel_i,
    input logic [31:0]       dat_i,
    input logic [31:0]       dat_o,
    input logic              ack_o,
    input logic              sleepMode,
    input logic [2:0]        analogChannel,
    input logic              holdConnect,
    input logic              converterEnable,
    input logic [9:0]        dacCode,
    input logic [NUM_CH-1:0] pinAnalog,
    input logic              refHighFromPin,
    input logic              refLowFromPin,
    input logic              irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // Shadow of the clock select, needed to know when sleep must stall
    // ****************************************************************
    logic [1:0] clkSh;
    logic       ctrlWr;
    assign ctrlWr = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
        && adr_i[7:2] == `SAC_IDX_CTRL;
    always @(posedge sys_clk) begin
        if (rst) begin
            clkSh <= 2'h0;
        end else if (ctrlWr) begin
            clkSh <= dat_i[7:6];
        end
    end

    property p_ack_once;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus answer is not one pulse");
    property p_bit1_zero;
        ack_o && !we_i && adr_i[7:2] == `SAC_IDX_CTRL |-> !dat_o[1];
    endproperty
    a_bit1_zero: assert property (p_bit1_zero) else $error("control bit 1 reads 1");
    property p_module_on;
        ctrlWr |-> ##2 converterEnable == $past(dat_i[0], 2);
    endproperty
    a_module_on: assert property (p_module_on) else $error("enable does not follow");
    property p_channel;
        ctrlWr && dat_i[5:3] < NUM_CH |-> ##2 analogChannel == $past(dat_i[5:3], 2);
    endproperty
    a_channel: assert property (p_channel) else $error("channel not routed");
    property p_refs;
        (!refHighFromPin || pinAnalog[3]) && (!refLowFromPin || pinAnalog[2]);
    endproperty
    a_refs: assert property (p_refs) else $error("reference pin left digital");
    property p_go_hold;
        ctrlWr && dat_i[2] && dat_i[0] && converterEnable |-> ##[1:3] !holdConnect;
    endproperty
    a_go_hold: assert property (p_go_hold) else $error("hold stays connected");
    property p_irq_clear;
        ack_o && !we_i && adr_i[7:2] == `SAC_IDX_IRQ_STATUS |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status read kept irq");
    property p_sleep_stop;
        (sleepMode && clkSh != `SAC_CLK_RC) [*3] |-> $stable(dacCode);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("ran in sleep");
    property p_holdoff;
        $rose(holdConnect) |-> !$past(holdConnect, 2) && !$past(holdConnect, 4);
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("hold reconnected early");
endmodule

bind sac_adc_control sac_adc_control_props #(.NUM_CH(NUM_CH)) sac_adc_control_props_inst (
    .sys_clk(sys_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleepMode(sleepMode), .analogChannel(analogChannel), .holdConnect(holdConnect),
    .converterEnable(converterEnable), .dacCode(dacCode), .pinAnalog(pinAnalog),
    .refHighFromPin(refHighFromPin), .refLowFromPin(refLowFromPin), .irq(irq));

//--- test/sac_adc_control_test.sv
// Self-checking bench of the converter control block: registers, conversions, sleep, irq.
// Assumes the analog model answers the comparator and makes the RC clock ticks.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_adc_control_test;
    localparam RC_PER = 5;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic        sleepMode = 1'b0;
    logic        slow = 1'b0;
    logic [9:0]  level [0:7];
    logic [31:0] q;
    logic [31:0] d;
    logic [5:0]  regs [6] = '{`SAC_IDX_CTRL, `SAC_IDX_RES_HIGH, `SAC_IDX_RES_LOW,
                              `SAC_IDX_PORT_CFG, `SAC_IDX_IRQ_STATUS, 6'h00};
    wire  [31:0] dat_o;
    wire  [9:0]  dacCode;
    wire  [7:0]  pinAnalog;
    wire  [2:0]  analogChannel;
    wire         ack_o, compIn, rcTick, holdConnect, converterEnable, irq;
    wire         refHighFromPin, refLowFromPin;
    int          err_total = 0;
    int          checks = 0;

    sac_adc_control #(.NUM_CH(8)) sac_adc_control_inst (
        .sys_clk(sys_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .compIn(compIn), .rcTick(rcTick), .sleepMode(sleepMode),
        .analogChannel(analogChannel), .holdConnect(holdConnect),
        .converterEnable(converterEnable), .dacCode(dacCode), .pinAnalog(pinAnalog),
        .refHighFromPin(refHighFromPin), .refLowFromPin(refLowFromPin), .irq(irq));
    sac_analog_model #(.RC_PER(RC_PER)) sac_analog_model_inst (
        .sys_clk(sys_clk), .slow(slow), .level(level), .analogChannel(analogChannel),
        .holdConnect(holdConnect), .dacCode(dacCode), .compIn(compIn), .rcTick(rcTick));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Bus, comparison and conversion tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] v,
                      input logic [3:0] s);
        @(posedge sys_clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        dat_i <= v;
        sel_i <= s;
        do @(posedge sys_clk); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx);
        wb(1'b0, idx, 32'h0000_0000, 4'h0);
    endtask

    function automatic logic [7:0] pins(input logic [9:0] v);
        pins = v[7:0];
        pins[`SAC_REFH_PIN] |= v[`SAC_PCFG_REFH];
        pins[`SAC_REFL_PIN] |= v[`SAC_PCFG_REFL];
    endfunction

    // A sleeping conversion on a divided clock must stall until the wake at 400 cycles
    task automatic conv(input logic [1:0] cs, input logic [2:0] ch, input logic slp);
        int n;
        int conv_clock_period;
        logic [31:0] hi;
        n = 0;
        conv_clock_period = cs == `SAC_CLK_FOSC2 ? 2 : cs == `SAC_CLK_FOSC8 ? 8 : cs == `SAC_CLK_FOSC32 ? 32 : RC_PER;
        // At osc/2 the first trial follows start by one cycle: a late comparator misses it
        slow <= (cs != `SAC_CLK_FOSC2) && ($urandom_range(1, 0) == 1);
        wb(1'b1, `SAC_IDX_CTRL, {24'h00_0000, cs, ch, 3'h1}, 4'h1);
        repeat (20) @(posedge sys_clk);
        sleepMode <= slp;
        wb(1'b1, `SAC_IDX_CTRL, {24'h00_0000, cs, ch, 3'h5}, 4'h1);
        while (irq !== 1'b1 && n < 900) begin
            @(posedge sys_clk);
            n++;
            if (n == 400) begin
                sleepMode <= 1'b0;
            end
        end
        if (slp && cs != `SAC_CLK_RC) begin
            check(n > 400, 1'b1);
        end else begin
            check(n >= 10 * conv_clock_period && n <= 12 * conv_clock_period + 4, 1'b1);
        end
        rd(`SAC_IDX_CTRL);
        check(q, {24'h00_0000, cs, ch, 3'h1});
        rd(`SAC_IDX_RES_HIGH);
        hi = q;
        rd(`SAC_IDX_RES_LOW);
        check(hi, {30'h0000_0000, level[ch][9:8]});
        check(q, {24'h00_0000, level[ch][7:0]});
        rd(`SAC_IDX_IRQ_STATUS);
        check(q, 32'h0000_0001);
        @(posedge sys_clk);
        check(irq, 1'b0);
    endtask

    // Longest path is six conversions of at most 900 cycles each plus register traffic
    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 60000);
        err_total++;
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h0000_b07d));
        foreach (level[i]) begin
            level[i] = 10'($urandom_range(1023, 0));
        end
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        wb(1'b1, 6'h00, 32'hFFFF_FFFF, 4'hF);
        foreach (regs[i]) begin
            rd(regs[i]);
            check(q, 32'h0000_0000);
        end
        check({converterEnable, holdConnect, irq}, 3'h0);
        wb(1'b1, `SAC_IDX_IRQ_MASK, 32'h0000_0001, 4'h1);
        wb(1'b1, `SAC_IDX_CTRL, 32'h0000_00C6, 4'h1);
        repeat (100) @(posedge sys_clk);
        check(irq, 1'b0);
        rd(`SAC_IDX_CTRL);
        check(q, 32'h0000_00C0);
        for (int c = 0; c < 4; c++) begin
            conv(2'(c), 3'($urandom_range(7, 0)), 1'b0);
        end
        conv(`SAC_CLK_RC, 3'($urandom_range(7, 0)), 1'b1);
        conv(`SAC_CLK_FOSC8, 3'($urandom_range(7, 0)), 1'b1);
        wb(1'b1, `SAC_IDX_CTRL, 32'h0000_0005, 4'h1);
        repeat (10) @(posedge sys_clk);
        wb(1'b1, `SAC_IDX_CTRL, 32'h0000_0000, 4'h1);
        repeat (100) @(posedge sys_clk);
        rd(`SAC_IDX_IRQ_STATUS);
        check(q, 32'h0000_0000);
        rd(`SAC_IDX_CTRL);
        check(q, 32'h0000_0000);
        wb(1'b1, `SAC_IDX_IRQ_MASK, 32'h0000_0000, 4'h1);
        wb(1'b1, `SAC_IDX_CTRL, 32'h0000_0001, 4'h1);
        repeat (20) @(posedge sys_clk);
        wb(1'b1, `SAC_IDX_CTRL, 32'h0000_0005, 4'h1);
        repeat (100) @(posedge sys_clk);
        check(irq, 1'b0);
        rd(`SAC_IDX_IRQ_STATUS);
        check(q, 32'h0000_0001);
        repeat (4) begin
            d = $urandom_range(1023, 0);
            wb(1'b1, `SAC_IDX_PORT_CFG, d, 4'h3);
            @(posedge sys_clk);
            check(pinAnalog, pins(d[9:0]));
            check({refLowFromPin, refHighFromPin}, d[9:8]);
            wb(1'b1, `SAC_IDX_PORT_CFG, ~d, 4'h1);
            @(posedge sys_clk);
            check(pinAnalog, pins({d[9:8], ~d[7:0]}));
        end
        tally_and_finish();
    end
endmodule
